// ### logic/flash_seq_defs.svh
// constants for the flash self-program sequencer
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH
`define UNLOCK_KEY_ADDR 8'he0
`define MODE_CTRL_ADDR 8'he1
`define MODE_CTRL_RESET 8'h00
`define MODE_ENABLE_BIT 7
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'hb9
`define OP_STANDBY 2'h0
`define OP_PAGE_PROGRAM 2'h1
`define OP_BYTE_WRITE 2'h2
`define OP_PAGE_ERASE 2'h3
`define FLASH_BASE 16'he000
`define FLASH_BYTES 8192
`define PAGE_BYTES 64
`define ERASE_TIME_US 2000
`define PROG_TIME_US 2000
`define CLK_MHZ 100
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define WR_TIMEOUT_CYCLES 1000
`endif

// ### logic/flash_seq_pkg.sv
// types for the flash self-program sequencer
package flash_seq_pkg;
   typedef enum logic [3:0]
   {
      st_idle = 4'b0001,
      st_key1 = 4'b0010,
      st_armed = 4'b0100,
      st_busy = 4'b1000
   } seq_state_t;
endpackage : flash_seq_pkg

// ### logic/flash_self_program_sequencer.sv
// flash self-program sequencer: unlock, mode, data latch, array control
`timescale 1ns/1ps
`include "flash_seq_defs.svh"
module flash_self_program_sequencer
   import flash_seq_pkg::*;
#(
   parameter int ERASE_CYCLES = `ERASE_CYCLES,
   parameter int PROG_CYCLES = `PROG_CYCLES,
   parameter int TIMEOUT_CYCLES = `WR_TIMEOUT_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cpu_wr,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   output logic cpu_stall,
   output logic [6:0] fl_page,
   output logic fl_erase,
   output logic fl_program,
   output logic [7:0] fl_latch_data [`PAGE_BYTES],
   output logic fl_ref_en,
   input wire logic opt_read_lock,
   input wire logic chip_erase,
   output logic opt_read_lock_eff,
   input wire logic [7:0] prog_rd_raw,
   output logic [7:0] prog_rd_data
);
   localparam int CW = $clog2(ERASE_CYCLES > PROG_CYCLES ? ERASE_CYCLES + 1 : PROG_CYCLES + 1);
   localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
   seq_state_t state_r;
   logic enable_r;
   logic [1:0] op_sel_r;
   logic [CW-1:0] cnt_r;
   logic [TW-1:0] tmo_r;
   logic lock_clr_r;
   logic [7:0] latch_r [`PAGE_BYTES];
   logic in_flash;
   logic key_wr;
   logic mode_wr;
   logic mode_rd;
   logic tmo_hit;
   logic trig;
   logic start_erase;
   logic start_program;
   logic cnt_done;

   function automatic logic flash_hit(input logic [15:0] a);
      flash_hit = a >= `FLASH_BASE;
   endfunction : flash_hit

   // sfr address decode
   function automatic logic sfr_hit(input logic [15:0] a, input logic [7:0] off);
      sfr_hit = a == {8'h00, off};
   endfunction : sfr_hit

   // whole 8K window, page index from address bits
   assign in_flash = flash_hit(cpu_addr);
   assign key_wr = cpu_wr && sfr_hit(cpu_addr, `UNLOCK_KEY_ADDR);
   assign mode_wr = cpu_wr && sfr_hit(cpu_addr, `MODE_CTRL_ADDR);
   assign mode_rd = sfr_rd && sfr_hit(cpu_addr, `MODE_CTRL_ADDR);
   assign tmo_hit = tmo_r == TW'(TIMEOUT_CYCLES);
   // armed store into flash, enable set
   assign trig = state_r == st_armed && cpu_wr && !tmo_hit
                 && in_flash && enable_r;
   assign start_erase = trig && op_sel_r == `OP_PAGE_ERASE;
   assign start_program = trig && op_sel_r == `OP_PAGE_PROGRAM;
   assign cnt_done = cnt_r == '0;

   // mode register
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         enable_r <= 1'b0;
         op_sel_r <= `OP_STANDBY;
      end
      else if (mode_wr && state_r != st_busy)
      begin
         enable_r <= cpu_wdata[`MODE_ENABLE_BIT];
         op_sel_r <= cpu_wdata[1:0];
      end
   end

   // unlock sequence and operation state
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         state_r <= st_idle;
      else
      begin
         case (state_r)
            st_idle:
            begin
               if (key_wr && cpu_wdata == `KEY_FIRST)
                  state_r <= st_key1;
            end
            st_key1:
            begin
               if (cpu_wr)
                  state_r <= (key_wr && cpu_wdata == `KEY_SECOND) ? st_armed : st_idle;
            end
            st_armed:
            begin
               if (start_erase || start_program)
                  state_r <= st_busy;
               else if (tmo_hit || cpu_wr)
                  state_r <= st_idle;
            end
            st_busy:
            begin
               if (cnt_done)
                  state_r <= st_idle;
            end
            default:
               state_r <= st_idle;
         endcase
      end
   end

   // armed-state timeout counter
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         tmo_r <= '0;
      else if (state_r == st_armed)
         tmo_r <= tmo_r + TW'(1);
      else
         tmo_r <= '0;
   end

   // busy duration counter
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         cnt_r <= '0;
      else if (start_erase)
         cnt_r <= CW'(ERASE_CYCLES);
      else if (start_program)
         cnt_r <= CW'(PROG_CYCLES);
      else if (state_r == st_busy && !cnt_done)
         cnt_r <= cnt_r - CW'(1);
   end

   // array strobes and page index; store data ignored
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fl_page <= '0;
         fl_erase <= 1'b0;
         fl_program <= 1'b0;
      end
      else
      begin
         fl_erase <= start_erase;
         fl_program <= start_program;
         if (start_erase || start_program)
            fl_page <= cpu_addr[12:6];
      end
   end

   // page data latch
   always_ff @(posedge ref_clk)
   begin
      if (trig && op_sel_r == `OP_BYTE_WRITE)
         latch_r[cpu_addr[5:0]] <= cpu_wdata;
   end
   assign fl_latch_data = latch_r;

   // read-lock option, cleared by chip erase
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         lock_clr_r <= 1'b0;
      else if (chip_erase)
         lock_clr_r <= 1'b1;
   end
   assign opt_read_lock_eff = opt_read_lock && !lock_clr_r && !chip_erase;

   // programmer read masking
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         prog_rd_data <= 8'h00;
      else
         prog_rd_data <= opt_read_lock_eff ? 8'h00 : prog_rd_raw;
   end

   // mode register readback, key reads zero
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         sfr_rdata <= 8'h00;
      else if (mode_rd)
         sfr_rdata <= {enable_r, 5'h00, op_sel_r};
      else
         sfr_rdata <= 8'h00;
   end

   // busy stall and reference enable
   assign cpu_stall = state_r == st_busy;
   assign fl_ref_en = enable_r;
endmodule : flash_self_program_sequencer

// ### dv/flash_seq_props.sv
// port assertions for the flash sequencer
`timescale 1ns/1ps
module flash_seq_props
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cpu_wr,
   input wire logic [15:0] cpu_addr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic cpu_stall,
   input wire logic fl_erase,
   input wire logic fl_program,
   input wire logic fl_ref_en,
   input wire logic chip_erase,
   input wire logic opt_read_lock_eff,
   input wire logic [7:0] prog_rd_data
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);
   property p_en; fl_erase || fl_program |-> $past(fl_ref_en); endproperty
   a_en: assert property (p_en) else $error("op disabled");
   property p_wr; fl_erase || fl_program |-> $past(cpu_wr); endproperty
   a_wr: assert property (p_wr) else $error("no trigger");
   property p_st; fl_erase |-> cpu_stall [*8]; endproperty
   a_st: assert property (p_st) else $error("no stall");
   property p_ro; $rose(cpu_stall) |-> fl_erase || fl_program; endproperty
   a_ro: assert property (p_ro) else $error("stray stall");
   property p_md; sfr_rd && cpu_addr == 16'h00e1 |=> sfr_rdata[7] == fl_ref_en; endproperty
   a_md: assert property (p_md) else $error("mode read");
   property p_ky; sfr_rd && cpu_addr == 16'h00e0 |=> sfr_rdata == 8'h00; endproperty
   a_ky: assert property (p_ky) else $error("key read");
   property p_lk; $past(opt_read_lock_eff) |-> prog_rd_data == 8'h00; endproperty
   a_lk: assert property (p_lk) else $error("lock leak");
   property p_ce; chip_erase |=> !opt_read_lock_eff; endproperty
   a_ce: assert property (p_ce) else $error("lock kept");
   cover property (fl_erase);
   cover property (fl_program);
   cover property (chip_erase);
endmodule : flash_seq_props
bind flash_self_program_sequencer flash_seq_props u_props (.*);

// ### dv/flash_array_model.sv
// flash array behind the sequencer
`timescale 1ns/1ps
module flash_array_model
(
   input wire logic ref_clk,
   input wire logic [6:0] fl_page,
   input wire logic fl_erase,
   input wire logic fl_program,
   input wire logic [7:0] fl_latch_data [64]
);
   logic [7:0] mem [8192];
   always @(posedge ref_clk)
      for (int i = 0; i < 64; i++)
         if (fl_erase || fl_program)
            mem[{fl_page, i[5:0]}] <= fl_erase ? 8'hff : fl_latch_data[i];
endmodule : flash_array_model

// ### dv/tb_top.sv
// flash sequencer testbench
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, rst_b, cpu_wr, sfr_rd, cpu_stall, fl_erase, fl_program, fl_ref_en;
   logic opt_read_lock, chip_erase, opt_read_lock_eff;
   logic [15:0] cpu_addr;
   logic [7:0] cpu_wdata, sfr_rdata, prog_rd_raw, prog_rd_data;
   logic [7:0] fl_latch_data [64];
   logic [6:0] fl_page;
   int miscompares, checked;
   flash_self_program_sequencer #(.ERASE_CYCLES(20), .PROG_CYCLES(20), .TIMEOUT_CYCLES(50)) DUT (.*);
   flash_array_model FM (.*);
   initial
   begin
      ref_clk = 0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("BAD %0t %h/%h", $time, g, e);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checked %0d bad %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_wr <= 1;
      cpu_addr <= a;
      cpu_wdata <= d;
      @(posedge ref_clk);
      cpu_wr <= 0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      sfr_rd <= 1;
      cpu_addr <= a;
      @(posedge ref_clk);
      sfr_rd <= 0;
      #1 chk(sfr_rdata, e);
   endtask : rd
   task automatic go(input logic [7:0] m, input logic [7:0] k, input int g, input logic x);
      int n;
      wr(16'h00e1, m);
      wr(16'h00e0, 8'h46);
      wr(16'h00e0, k);
      if (g == 1)
         wr(16'h00e1, m);
      else
         repeat (g) @(posedge ref_clk);
      wr(16'he010, 8'h40);
      @(posedge ref_clk);
      #1 chk(8'(cpu_stall), 8'(x));
      for (n = 0; n < 99 && cpu_stall !== 0; n++)
         @(posedge ref_clk);
      if (n == 99)
      begin
         miscompares++;
         tally_and_finish();
      end
   endtask : go
   task automatic t_prog;
      rd(16'h00e1, 8'h00);
      rd(16'h00e0, 8'h00);
      wr(16'h00e1, 8'h82);
      rd(16'h00e1, 8'h82);
      chk(8'(fl_ref_en), 8'h01);
      repeat (1000) @(posedge ref_clk);
      for (int i = 0; i < 64; i++)
      begin
         wr(16'h00e0, 8'h46);
         wr(16'h00e0, 8'hb9);
         wr(16'he000 + 16'(i), 8'(i) ^ 8'h5a);
      end
      go(8'h81, 8'hb9, 0, 1);
      for (int i = 0; i < 64; i++)
         chk(FM.mem[i], 8'(i) ^ 8'h5a);
      go(8'h83, 8'hb9, 0, 1);
      chk(FM.mem[63], 8'hff);
      $display("prog done");
   endtask : t_prog
   task automatic t_bad;
      go(8'h81, 8'h47, 0, 0);
      go(8'h83, 8'hb9, 1, 0);
      go(8'h83, 8'hb9, 60, 0);
      go(8'h80, 8'hb9, 0, 0);
      go(8'h01, 8'hb9, 0, 0);
      chk(FM.mem[0], 8'hff);
      wr(16'h00e1, 8'h00);
      $display("refuse done");
   endtask : t_bad
   task automatic t_lock;
      @(posedge ref_clk);
      opt_read_lock <= 1;
      repeat (2) @(posedge ref_clk);
      #1 chk(prog_rd_data, 8'h00);
      chk(8'(opt_read_lock_eff), 8'h01);
      @(posedge ref_clk);
      chip_erase <= 1;
      @(posedge ref_clk);
      chip_erase <= 0;
      repeat (2) @(posedge ref_clk);
      #1 chk(prog_rd_data, 8'h3c);
      chk(8'(opt_read_lock_eff), 8'h00);
      $display("lock done");
   endtask : t_lock
   initial
   begin
      {rst_b, cpu_wr, sfr_rd, opt_read_lock, chip_erase, cpu_addr, cpu_wdata} = 0;
      prog_rd_raw = 8'h3c;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1;
      t_prog();
      t_bad();
      t_lock();
      tally_and_finish();
   end
endmodule : tb_top
